// File: ubmu_chk.sv
`timescale 1ns/100ps
`include "ubmu_consts.vh"
module ubmu_chk (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire        pslverr,
   input wire        bus_valid,
   input wire [31:0] bus_addr,
   input wire        bus_engine,
   input wire        bus_fetch,
   input wire        bus_write,
   input wire [1:0]  bus_size,
   input wire        bus_dual,
   input wire        branch_taken,
   input wire [1:0]  branch_kind,
   input wire        hp_exception_accept,
   input wire        break_accept,
   input wire        break_req
);
   reg  [7:0]  sel;
   reg  [31:0] bar;
   reg  [31:0] msk;
   reg  [1:0]  ovr;
   wire        wr = psel && penable && pwrite;
   wire        dm = bus_valid && !bus_fetch && sel[5] && (bus_engine ? sel[7] : sel[6]) &&
                    (bus_write ? sel[3] : sel[2]) && (sel[1:0] == 2'h0 || sel[1:0] == bus_size) &&
                    ((bus_addr ^ bar) & ~msk) == 32'h00000000;
   // ==========================================================
   // Shadow copies of the match settings and the fetch position after a branch.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel <= 8'h00;
         bar <= 32'h00000000;
         msk <= 32'h00000000;
         ovr <= 2'h0;
      end else begin
         if (wr && paddr == `UBMU_OFF_CYCLE_SEL) sel <= pwdata[7:0];
         if (wr && paddr == `UBMU_OFF_ADDR_HIGH) bar[31:16] <= pwdata[15:0];
         if (wr && paddr == `UBMU_OFF_ADDR_LOW) bar[15:0] <= pwdata[15:0];
         if (wr && paddr == `UBMU_OFF_MASK_HIGH) msk[31:16] <= pwdata[15:0];
         if (wr && paddr == `UBMU_OFF_MASK_LOW) msk[15:0] <= pwdata[15:0];
         if (bus_valid && bus_fetch && !bus_engine) begin
            if (branch_taken && (branch_kind == `UBMU_BR_NODELAY || branch_kind == `UBMU_BR_TRAP)) begin
               ovr <= 2'h3;
            end else if (ovr != 2'h0) begin
               ovr <= ovr - 2'h1;
            end
         end
      end
   end
   // ==========================================================
   // Properties.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_pend;
      break_req && !break_accept && !hp_exception_accept && !(wr && paddr == `UBMU_OFF_STATUS && pwdata[0]);
   endsequence
   sequence s_idle_cyc;
      bus_valid && !break_req;
   endsequence
   property p_req_hold; s_pend |=> break_req; endproperty
   property p_hp_drop; hp_exception_accept && !bus_valid |=> !break_req; endproperty
   property p_data_hit; dm && !hp_exception_accept |=> break_req; endproperty
   property p_data_miss; s_idle_cyc ##0 (!bus_fetch && !dm) |=> !break_req; endproperty
   property p_sel_zero;
      s_idle_cyc ##0 (sel[7:6] == 2'h0 || sel[5:4] == 2'h0 || sel[3:2] == 2'h0) |=> !break_req;
   endproperty
   property p_engine_fetch; s_idle_cyc ##0 (bus_engine && sel[7:4] == 4'h9) |=> !break_req; endproperty
   property p_ovr;
      s_idle_cyc ##0 (bus_fetch && !bus_engine && !bus_dual && (ovr == 2'h1 || (ovr > 2'h1 && !sel[5])))
         |=> !break_req;
   endproperty
   property p_slverr;
      pslverr |-> psel && penable && (paddr[1:0] != 2'h0 || paddr > `UBMU_OFF_HIT_COUNT);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("break request fell while still pending");
   a_hp_drop: assert property (p_hp_drop) else $error("break request kept after exception");
   a_data_hit: assert property (p_data_hit) else $error("matching data cycle gave no break");
   a_data_miss: assert property (p_data_miss) else $error("non-matching data cycle broke");
   a_sel_zero: assert property (p_sel_zero) else $error("break with a zero select field");
   a_engine_fetch: assert property (p_engine_fetch) else $error("engine cycle broke on fetch select");
   a_ovr: assert property (p_ovr) else $error("overrun or destination fetch broke");
   a_slverr: assert property (p_slverr) else $error("error response on a mapped access");
endmodule
bind ubmu_top ubmu_chk u_ubmu_chk (.*);

// File: ubmu_consts.vh
`ifndef UBMU_CONSTS_VH
`define UBMU_CONSTS_VH

// ==========================================================================
// Register map, byte addresses on the APB.
`define UBMU_ADDR_W          12
`define UBMU_OFF_ADDR_HIGH   12'h000
`define UBMU_OFF_ADDR_LOW    12'h004
`define UBMU_OFF_MASK_HIGH   12'h008
`define UBMU_OFF_MASK_LOW    12'h00C
`define UBMU_OFF_CYCLE_SEL   12'h010
`define UBMU_OFF_STATUS      12'h014
`define UBMU_OFF_LAST_ADDR   12'h018
`define UBMU_OFF_HIT_COUNT   12'h01C

// ==========================================================================
// Reset values.
`define UBMU_RST_HALF        16'h0000
`define UBMU_RST_SEL         8'h00
`define UBMU_RST_WORD        32'h00000000
`define UBMU_RST_COUNT       16'h0000

// ==========================================================================
// Break cycle select field positions.
`define UBMU_SEL_MST_HI      7
`define UBMU_SEL_MST_LO      6
`define UBMU_SEL_DATA        5
`define UBMU_SEL_FETCH       4
`define UBMU_SEL_WRITE       3
`define UBMU_SEL_READ        2
`define UBMU_SEL_SIZE_HI     1
`define UBMU_SEL_SIZE_LO     0

// ==========================================================================
// Status field positions.
`define UBMU_ST_PENDING      0
`define UBMU_ST_OVR_DATA     1
`define UBMU_ST_DUAL_SECOND  2

// ==========================================================================
// Operand size codes and miscellany.
`define UBMU_SZ_IGNORE       2'h0
`define UBMU_SZ_BYTE         2'h1
`define UBMU_SZ_WORD         2'h2
`define UBMU_SZ_LONG         2'h3
`define UBMU_INSTR_STEP      32'h00000002

// ==========================================================================
// Taken-branch kinds reported by the processor.
`define UBMU_BR_NONE         2'h0
`define UBMU_BR_NODELAY      2'h1
`define UBMU_BR_TRAP         2'h2
`define UBMU_BR_DELAYED      2'h3

`endif

// File: ubmu_fetch_seq.v
`timescale 1ns/100ps
`include "ubmu_consts.vh"

module ubmu_fetch_seq (
   input  wire       pclk,
   input  wire       presetn,
   input  wire       fetch_strobe,
   input  wire       branch_taken,
   input  wire [1:0] branch_kind,
   output reg        is_overrun,
   output reg        is_nodelay_dest
);

   // =======================================================================
   // Fetch position after a taken branch.
   localparam [2:0] ST_IDLE   = 3'h0;
   localparam [2:0] ST_OVR_A  = 3'h1;
   localparam [2:0] ST_OVR_B  = 3'h2;
   localparam [2:0] ST_DEST_N = 3'h3;
   localparam [2:0] ST_SLOT   = 3'h4;
   localparam [2:0] ST_OVR_D  = 3'h5;

   reg [2:0] state;
   reg [2:0] next_state;

   always @* begin
      next_state = state;
      if (fetch_strobe) begin
         case (state)
            ST_IDLE: begin
               if (branch_taken) begin
                  if (branch_kind == `UBMU_BR_NODELAY || branch_kind == `UBMU_BR_TRAP) begin
                     next_state = ST_OVR_A;
                  end else if (branch_kind == `UBMU_BR_DELAYED) begin
                     next_state = ST_SLOT;
                  end
               end
            end
            ST_OVR_A:  next_state = ST_OVR_B;
            ST_OVR_B:  next_state = ST_DEST_N;
            ST_DEST_N: next_state = ST_IDLE;
            ST_SLOT:   next_state = ST_OVR_D;
            ST_OVR_D:  next_state = ST_IDLE;
            default:   next_state = ST_IDLE;
         endcase
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always @* begin
      is_overrun      = (state == ST_OVR_A) || (state == ST_OVR_B) || (state == ST_OVR_D);
      is_nodelay_dest = (state == ST_DEST_N);
   end

endmodule

// File: ubmu_partner.sv
`timescale 1ns/100ps
`include "ubmu_consts.vh"
module ubmu_partner (
   input  wire        pclk,
   output reg         bus_valid,
   output reg  [31:0] bus_addr,
   output reg         bus_engine,
   output reg         bus_fetch,
   output reg         bus_write,
   output reg  [1:0]  bus_size,
   output reg         bus_dual,
   output reg         branch_taken,
   output reg  [1:0]  branch_kind,
   output reg         hp_exception_accept,
   output reg         break_accept
);
   initial begin
      {bus_valid, bus_addr, bus_engine, bus_fetch, bus_write, bus_size, bus_dual} = 39'h0;
      {branch_taken, branch_kind, hp_exception_accept, break_accept} = 5'h00;
   end
   // Idle address, master, direction and size lines toggle so that stale values are never mistaken for a cycle.
   task cyc(input [31:0] a, input e, input f, input w, input [1:0] sz, input d, input [1:0] k);
      begin
         @(posedge pclk);
         bus_valid    <= 1'b1;
         bus_addr     <= a;
         bus_engine   <= e & ~f;
         bus_fetch    <= f;
         bus_write    <= w & ~f;
         bus_size     <= f ? `UBMU_SZ_WORD : sz;
         bus_dual     <= d & f;
         branch_taken <= k != `UBMU_BR_NONE;
         branch_kind  <= k;
         @(posedge pclk);
         bus_valid    <= 1'b0;
         bus_addr     <= ~a;
         bus_engine   <= ~bus_engine;
         bus_write    <= ~bus_write;
         bus_size     <= ~bus_size;
         bus_dual     <= 1'b0;
         branch_taken <= 1'b0;
      end
   endtask
   task ack(input integer n, input drop);
      begin
         repeat (n) @(posedge pclk);
         @(posedge pclk);
         if (drop) hp_exception_accept <= 1'b1;
         else break_accept <= 1'b1;
         @(posedge pclk);
         hp_exception_accept <= 1'b0;
         break_accept        <= 1'b0;
      end
   endtask
endmodule

// File: ubmu_top.v
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`include "ubmu_consts.vh"

// Notes on behaviour
// - Cycle select holds master, fetch/data, direction and size fields; size 0 ignores size.
// - Any master, fetch/data or direction field of 00 blocks every break.
// - Processor word write at the programmed address raises a break.
// - Word read at an odd programmed address never matches even word cycles.
// - Engine longword read at the programmed address raises a break.
// - Engine-only master with fetch type never breaks; engines do not fetch.
// - Second of a dual fetch still breaks despite a later condition rewrite.
// - Taken plain branch: branch, two overrun fetches, then destination fetch.
// - Taken software trap: trap, two overrun fetches, then destination fetch.
// - Taken delayed branch: branch, delay slot, one overrun, then destination fetch.
// - Overrun fetches never raise an instruction fetch break.
// - With data and fetch breaks both enabled, a matching overrun counts as data.
// - A higher-priority exception accepted in decode may drop the pending break.
// - First destination fetch after a non-delay branch never raises a fetch break.
module ubmu_top (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        bus_valid,
   input  wire [31:0] bus_addr,
   input  wire        bus_engine,
   input  wire        bus_fetch,
   input  wire        bus_write,
   input  wire [1:0]  bus_size,
   input  wire        bus_dual,
   input  wire        branch_taken,
   input  wire [1:0]  branch_kind,
   input  wire        hp_exception_accept,
   input  wire        break_accept,
   output reg         break_req
);

   // =======================================================================
   // Condition check shared by the primary and the dual-fetch second slot.
   function cond_hit;
      input [31:0] addr;
      input        engine;
      input        fetch;
      input        wr;
      input [1:0]  size;
      input [31:0] brk_addr;
      input [31:0] brk_mask;
      input [7:0]  sel;
      reg          mst_ok;
      reg          type_ok;
      reg          dir_ok;
      reg          size_ok;
      reg          addr_ok;
      begin
         // Master, type and direction fields are pairs of enables, so 00 never passes; size 00 always passes.
         mst_ok  = engine ? sel[`UBMU_SEL_MST_HI] : sel[`UBMU_SEL_MST_LO];
         type_ok = fetch ? sel[`UBMU_SEL_FETCH] : sel[`UBMU_SEL_DATA];
         dir_ok  = wr ? sel[`UBMU_SEL_WRITE] : sel[`UBMU_SEL_READ];
         size_ok = (sel[`UBMU_SEL_SIZE_HI:`UBMU_SEL_SIZE_LO] == `UBMU_SZ_IGNORE) ||
                   (sel[`UBMU_SEL_SIZE_HI:`UBMU_SEL_SIZE_LO] == size);
         addr_ok = (((addr ^ brk_addr) & ~brk_mask) == `UBMU_RST_WORD);
         cond_hit = mst_ok & type_ok & dir_ok & size_ok & addr_ok;
      end
   endfunction

   // =======================================================================
   // Register storage.
   reg  [15:0] break_addr_high;
   reg  [15:0] break_addr_low;
   reg  [15:0] break_mask_high;
   reg  [15:0] break_mask_low;
   reg  [7:0]  break_cycle_select;
   reg         pending;
   reg         ovr_data_hit;
   reg         dual_second_hit;
   reg  [31:0] last_hit_addr;
   reg  [15:0] hit_count;

   wire [31:0] brk_addr = {break_addr_high, break_addr_low};
   wire [31:0] brk_mask = {break_mask_high, break_mask_low};

   // =======================================================================
   // APB decode.
   wire setup_phase  = psel & ~penable;
   wire access_phase = psel & penable;
   wire hit_addr_hi  = (paddr == `UBMU_OFF_ADDR_HIGH);
   wire hit_addr_lo  = (paddr == `UBMU_OFF_ADDR_LOW);
   wire hit_mask_hi  = (paddr == `UBMU_OFF_MASK_HIGH);
   wire hit_mask_lo  = (paddr == `UBMU_OFF_MASK_LOW);
   wire hit_sel      = (paddr == `UBMU_OFF_CYCLE_SEL);
   wire hit_status   = (paddr == `UBMU_OFF_STATUS);
   wire hit_last     = (paddr == `UBMU_OFF_LAST_ADDR);
   wire hit_cnt_sel  = (paddr == `UBMU_OFF_HIT_COUNT);
   wire mapped       = hit_addr_hi | hit_addr_lo | hit_mask_hi | hit_mask_lo |
                       hit_sel | hit_status | hit_last | hit_cnt_sel;
   wire wr_en        = access_phase & pwrite & mapped;

   // The slave never inserts wait states.
   assign pready  = 1'b1;
   assign pslverr = access_phase & ~mapped;

   // =======================================================================
   // Fetch classification after taken branches.
   wire cpu_fetch = bus_valid & bus_fetch & ~bus_engine;
   wire is_overrun;
   wire is_nodelay_dest;

   ubmu_fetch_seq u_fetch_seq (
      .pclk            (pclk),
      .presetn         (presetn),
      .fetch_strobe    (cpu_fetch),
      .branch_taken    (branch_taken),
      .branch_kind     (branch_kind),
      .is_overrun      (is_overrun),
      .is_nodelay_dest (is_nodelay_dest)
   );

   // =======================================================================
   // Match evaluation for the current bus cycle.
   wire both_types = break_cycle_select[`UBMU_SEL_DATA] & break_cycle_select[`UBMU_SEL_FETCH];

   // An ordinary cycle, evaluated with its true type.
   wire plain_hit = bus_valid &
                    cond_hit(bus_addr, bus_engine, bus_fetch, bus_write, bus_size,
                             brk_addr, brk_mask, break_cycle_select);

   // An overrun fetch re-evaluated as a data read.
   wire ovr_as_data = cpu_fetch & is_overrun & both_types &
                      cond_hit(bus_addr, 1'b0, 1'b0, 1'b0, `UBMU_SZ_WORD,
                               brk_addr, brk_mask, break_cycle_select);

   // The second instruction of a dual fetch, checked in the same bus cycle
   // so that a rewrite made after the first fetch cannot hide it.
   wire [31:0] second_addr = bus_addr + `UBMU_INSTR_STEP;
   wire dual_hit = cpu_fetch & bus_dual & ~is_overrun & ~is_nodelay_dest &
                   cond_hit(second_addr, 1'b0, 1'b1, 1'b0, `UBMU_SZ_WORD,
                            brk_addr, brk_mask, break_cycle_select);

   // Fetch hits on overrun and non-delay destination fetches are discarded.
   wire fetch_blocked = cpu_fetch & (is_overrun | is_nodelay_dest);
   wire primary_hit   = plain_hit & ~fetch_blocked;
   wire any_hit       = primary_hit | ovr_as_data | dual_hit;

   // =======================================================================
   // Pending break toward the interrupt arbiter.
   wire sw_clear   = wr_en & hit_status & pwdata[`UBMU_ST_PENDING];
   wire drop_break = hp_exception_accept;
   wire clear_any  = sw_clear | break_accept | drop_break;
   wire next_pending = any_hit | (pending & ~clear_any);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending         <= 1'b0;
         break_req       <= 1'b0;
         ovr_data_hit    <= 1'b0;
         dual_second_hit <= 1'b0;
         last_hit_addr   <= `UBMU_RST_WORD;
         hit_count       <= `UBMU_RST_COUNT;
      end else begin
         // A new hit wins over any clear in the same cycle.
         pending   <= next_pending;
         break_req <= next_pending;
         if (any_hit) begin
            ovr_data_hit    <= ovr_as_data & ~primary_hit;
            dual_second_hit <= dual_hit & ~primary_hit;
            last_hit_addr   <= (dual_hit & ~primary_hit & ~ovr_as_data) ? second_addr : bus_addr;
            hit_count       <= hit_count + 16'h0001;
         end else if (wr_en & hit_cnt_sel) begin
            hit_count <= `UBMU_RST_COUNT;
         end
      end
   end

   // =======================================================================
   // Register writes.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         break_addr_high    <= `UBMU_RST_HALF;
         break_addr_low     <= `UBMU_RST_HALF;
         break_mask_high    <= `UBMU_RST_HALF;
         break_mask_low     <= `UBMU_RST_HALF;
         break_cycle_select <= `UBMU_RST_SEL;
      end else if (wr_en) begin
         if (hit_addr_hi) begin
            break_addr_high <= pwdata[15:0];
         end
         if (hit_addr_lo) begin
            break_addr_low <= pwdata[15:0];
         end
         if (hit_mask_hi) begin
            break_mask_high <= pwdata[15:0];
         end
         if (hit_mask_lo) begin
            break_mask_low <= pwdata[15:0];
         end
         if (hit_sel) begin
            break_cycle_select <= pwdata[7:0];
         end
      end
   end

   // =======================================================================
   // Read data, captured in the setup cycle and held through the access.
   reg [31:0] next_prdata;

   always @* begin
      next_prdata = `UBMU_RST_WORD;
      if (hit_addr_hi) begin
         next_prdata[15:0] = break_addr_high;
      end else if (hit_addr_lo) begin
         next_prdata[15:0] = break_addr_low;
      end else if (hit_mask_hi) begin
         next_prdata[15:0] = break_mask_high;
      end else if (hit_mask_lo) begin
         next_prdata[15:0] = break_mask_low;
      end else if (hit_sel) begin
         next_prdata[7:0] = break_cycle_select;
      end else if (hit_status) begin
         next_prdata[`UBMU_ST_PENDING]     = pending;
         next_prdata[`UBMU_ST_OVR_DATA]    = ovr_data_hit;
         next_prdata[`UBMU_ST_DUAL_SECOND] = dual_second_hit;
      end else if (hit_last) begin
         next_prdata = last_hit_addr;
      end else if (hit_cnt_sel) begin
         next_prdata[15:0] = hit_count;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `UBMU_RST_WORD;
      end else if (setup_phase & ~pwrite) begin
         prdata <= next_prdata;
      end
   end

endmodule

// File: ubmu_top_tb.sv
`timescale 1ns/100ps
`include "ubmu_consts.vh"
module ubmu_top_tb;
   reg         pclk = 1'b0;
   reg         presetn = 1'b0;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h00000000;
   wire [31:0] prdata;
   wire [31:0] bus_addr;
   wire [1:0]  bus_size;
   wire [1:0]  branch_kind;
   wire        pready, pslverr, bus_valid, bus_engine, bus_fetch, bus_write, bus_dual;
   wire        branch_taken, hp_exception_accept, break_accept, break_req;
   integer     errors = 0, total_checks = 0, cycles = 0, mcnt = 0, i, j, k;
   reg  [31:0] mbar, mmsk, rd, a;
   reg  [7:0]  msel;
   reg         er;
   ubmu_top u_ubmu_top (.*);
   ubmu_partner u_ubmu_partner (.*);
   always #10 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         tally_and_finish;
      end
   end
   task tally_and_finish;
      begin
         $display("checks %0d errors %0d", total_checks, errors);
         if (errors == 0 && total_checks > 0) begin
            $display("verification passed");
         end else begin
            $display("verification failed");
         end
         $finish;
      end
   endtask
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task apb(input w, input [11:0] ad, input [31:0] d);
      begin
         @(posedge pclk);
         psel    <= 1'b1;
         pwrite  <= w;
         paddr   <= ad;
         pwdata  <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         rd = prdata;
         er = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task rdc(input [11:0] ad, input [31:0] exp);
      begin
         apb(1'b0, ad, 32'h00000000);
         chk("register", rd, exp);
      end
   endtask
   task set(input [31:0] b, input [31:0] m, input [7:0] s);
      begin
         mbar = b;
         mmsk = m;
         msel = s;
         apb(1'b1, `UBMU_OFF_ADDR_HIGH, {16'h0000, b[31:16]});
         apb(1'b1, `UBMU_OFF_ADDR_LOW, {16'h0000, b[15:0]});
         apb(1'b1, `UBMU_OFF_MASK_HIGH, {16'h0000, m[31:16]});
         apb(1'b1, `UBMU_OFF_MASK_LOW, {16'h0000, m[15:0]});
         apb(1'b1, `UBMU_OFF_CYCLE_SEL, {24'h000000, s});
      end
   endtask
   // Class c: 0 executed cycle, 1 overrun fetch, 2 first destination after a plain branch or trap.
   function automatic bit ehit(input [31:0] ad, input e, input f, input w, input [1:0] sz, input integer c);
      ehit = (e ? msel[7] : msel[6]) && (w ? msel[3] : msel[2]) && (msel[1:0] == 2'h0 || msel[1:0] == sz) &&
             ((ad ^ mbar) & ~mmsk) == 32'h00000000 &&
             (c == 1 ? msel[5] && msel[4] : (c == 2 ? 1'b0 : (f ? msel[4] : msel[5])));
   endfunction
   task go(input [31:0] ad, input e, input f, input w, input [1:0] sz, input d, input [1:0] bk,
           input integer c, input acc);
      reg h;
      begin
         u_ubmu_partner.cyc(ad, e, f, w, sz, d, bk);
         #1;
         h = ehit(ad, e, f, w, sz, c) || (d && ehit(ad + 32'h00000002, e, f, w, sz, c));
         mcnt = mcnt + h;
         chk("break_req", {31'h0, break_req}, {31'h0, h});
         if (acc) u_ubmu_partner.ack($urandom % 3, 1'b0);
      end
   endtask
   initial begin
      void'($urandom(32'h9F6D9560));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 8; i = i + 1) rdc(12'(4 * i), 32'h00000000);
      apb(1'b0, 12'h020, 32'h00000000);
      chk("unmapped_err", {31'h0, er}, 32'h00000001);
      chk("unmapped_data", rd, 32'h00000000);
      apb(1'b1, `UBMU_OFF_ADDR_HIGH, 32'hFFFFFFFF);
      rdc(`UBMU_OFF_ADDR_HIGH, 32'h0000FFFF);
      set(32'h00123456, 32'h00000000, 8'h6A);
      go(32'h00123456, 1'b0, 1'b0, 1'b1, `UBMU_SZ_WORD, 1'b0, `UBMU_BR_NONE, 0, 1'b1);
      rdc(`UBMU_OFF_LAST_ADDR, 32'h00123456);
      set(32'h00A80391, 32'h00000000, 8'h66);
      go(32'h00A80390, 1'b0, 1'b0, 1'b0, `UBMU_SZ_WORD, 1'b0, `UBMU_BR_NONE, 0, 1'b1);
      set(32'h0076BCDC, 32'h00000000, 8'hA7);
      go(32'h0076BCDC, 1'b1, 1'b0, 1'b0, `UBMU_SZ_LONG, 1'b0, `UBMU_BR_NONE, 0, 1'b1);
      set(32'h002345C8, 32'h00000000, 8'h94);
      go(32'h002345C8, 1'b1, 1'b0, 1'b0, `UBMU_SZ_WORD, 1'b0, `UBMU_BR_NONE, 0, 1'b1);
      set(32'h00123456, 32'h00000000, 8'h6A);
      go(32'h00123456, 1'b0, 1'b0, 1'b1, `UBMU_SZ_WORD, 1'b0, `UBMU_BR_NONE, 0, 1'b0);
      u_ubmu_partner.ack(0, 1'b1);
      #1;
      chk("dropped", {31'h0, break_req}, 32'h00000000);
      set(32'h00001002, 32'h00000000, 8'h54);
      go(32'h00001000, 1'b0, 1'b1, 1'b0, `UBMU_SZ_WORD, 1'b1, `UBMU_BR_NONE, 0, 1'b0);
      apb(1'b1, `UBMU_OFF_CYCLE_SEL, 32'h00000000);
      chk("dual_hold", {31'h0, break_req}, 32'h00000001);
      rdc(`UBMU_OFF_STATUS, 32'h00000005);
      u_ubmu_partner.ack(1, 1'b0);
      for (j = 0; j < 2; j = j + 1) begin
         for (k = 1; k < 4; k = k + 1) begin
            set(32'h00000000, 32'hFFFFFFFF, j ? 8'h74 : 8'h54);
            a = 32'h00000400;
            go(a, 1'b0, 1'b1, 1'b0, `UBMU_SZ_WORD, 1'b0, k[1:0], 0, 1'b1);
            for (i = 0; i < 4; i = i + 1) begin
               a = a + 32'h00000002;
               go(a, 1'b0, 1'b1, 1'b0, `UBMU_SZ_WORD, 1'b0, `UBMU_BR_NONE,
                  (k == 3) ? (i == 1) : (i < 2 ? 1 : (i == 2 ? 2 : 0)), 1'b1);
               if (j == 1 && i == 1) rdc(`UBMU_OFF_STATUS, 32'h00000002);
            end
         end
      end
      for (i = 0; i < 40; i = i + 1) begin
         a = $urandom;
         set(a, $urandom & 32'h0000000F, 8'($urandom));
         k = $urandom % 2;
         go(a ^ ($urandom & 32'h0000001E), k ? 1'b0 : 1'($urandom), k[0], k ? 1'b0 : 1'($urandom),
            k ? `UBMU_SZ_WORD : 2'($urandom % 3 + 1), 1'b0, `UBMU_BR_NONE, 0, 1'b1);
      end
      rdc(`UBMU_OFF_HIT_COUNT, {16'h0000, mcnt[15:0]});
      apb(1'b1, `UBMU_OFF_HIT_COUNT, 32'h00000000);
      rdc(`UBMU_OFF_HIT_COUNT, 32'h00000000);
      tally_and_finish;
   end
endmodule
